/* File: shared/wdbf_cfg.svh */
// constants for the watchdog and bus fault timer block
`ifndef WDBF_CFG_SVH
`define WDBF_CFG_SVH

// system clock and the tick clock that paces both timers
`define WDBF_CLK_HZ 40000000
`define WDBF_TICK_HZ 100000
// system clock cycles in one tick period
`define WDBF_TICK_CYC (`WDBF_CLK_HZ / `WDBF_TICK_HZ)

// watchdog reset values
`define WDBF_RELOAD_RST 16'h0000
`define WDBF_CNT_RST 16'h0000

// fault register layout
`define WDBF_FAULT_RST 16'h0000
`define WDBF_BIT_MEM_TO 8
`define WDBF_BIT_IO_TO 5

// bus timeout fires on this tick falling edge after the strobe falls
`define WDBF_TO_TICKS 2'h2
`define WDBF_TICKS_RST 2'h0

`endif

/* File: shared/wdbf_pkg.sv */
// types for the watchdog and bus fault timer block
package wdbf_pkg;

  // bus fault timer states
  typedef enum logic [1:0] {
    BFT_IDLE,
    BFT_WAIT,
    BFT_SUPPRESS
  } wdbf_bft_e;

endpackage

/* File: verilog/wdbf_fall_det.sv */
// falling edge detector for a synchronous level input
`timescale 1ns/100ps
`default_nettype none

module wdbf_fall_det (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // level in, edge pulse out
  input wire logic level_in,
  output logic fall_pulse
);

  // previous level, idles high so reset gives no false edge
  logic prev_ff;

  // track previous value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= level_in;
    end
  end

  // high then low marks a fall
  assign fall_pulse = prev_ff & ~level_in;

endmodule // wdbf_fall_det

`default_nettype wire

/* File: verilog/wdbf_top.sv */
// watchdog counter and bus fault timer
// What this block does
// R01: 16-bit watchdog counts each tick falling edge
// R02: reload register resets zero, takes any value
// R03: zero reload longest; nothing stops counting
// R04: watchdog runs from reset, no enable
// R05: overflow drives expiry low until reload command
// R06: timeout spans about 10us to 0.65s
// R07: bus timer starts at strobe fall, ready clears
// R08: no ready in 1-2 ticks sets bit 8/5
// R09: timeout raises level 1, suppresses strobes, aborts
// R10: timeout abandons instruction, vectors if unmasked
// R11: timeout-disable low holds timer reset, silent
// R12: tick clock is a 100kHz pulse train
// R13: fault bits stick until read-and-clear command
// R14: reload copies value, overflow at FFFF wrap
// R15: devices return ready within one tick
`include "wdbf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module wdbf_top
  import wdbf_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int FAULT_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // tick clock, synchronous to CLK
  input wire logic TICK_CLOCK,
  // watchdog software side
  input wire logic RELOAD_WR,
  input wire logic [CNT_W-1:0] RELOAD_DATA,
  input wire logic WDOG_GO,
  output logic WATCHDOG_EXPIRED_N,
  // bus transfer monitoring
  input wire logic DATA_STROBE_N,
  input wire logic XFER_IS_IO,
  input wire logic BUS_READY_N,
  input wire logic TIMEOUT_DISABLE_N,
  // fault register access
  input wire logic READ_CLEAR_FAULT_CMD,
  output logic [FAULT_W-1:0] FAULT_REGISTER,
  // interrupt and sequencer side
  input wire logic LEVEL1_UNMASKED,
  output logic LEVEL1_INT_REQ,
  output logic STROBE_SUPPRESS,
  output logic BUS_ABORT,
  output logic INSTR_ABANDON,
  output logic LEVEL1_VECTOR
);

  // edge pulses
  logic tick_fall; // tick clock fell this cycle
  logic strobe_fall; // data strobe fell this cycle

  // watchdog state
  logic [CNT_W-1:0] wdg_cnt_ff; // free running counter
  logic [CNT_W-1:0] reload_ff; // software reload value
  logic expired_n_ff; // expiry output
  logic wdg_ovf; // wrap from all ones to zero

  // bus fault timer state
  wdbf_bft_e bft_state_ff;
  logic [1:0] ticks_ff; // tick falls seen since strobe fall
  logic is_io_ff; // transfer type caught at strobe fall
  logic bus_to; // timeout fires this cycle
  logic [FAULT_W-1:0] fault_ff; // sticky fault bits
  logic [FAULT_W-1:0] fault_set; // bits to set this cycle
  logic l1_req_ff; // level 1 request pulse
  logic abort_ff; // bus abort pulse
  logic abandon_ff; // instruction abandon pulse
  logic vector_ff; // level 1 vector pulse
  logic suppress_ff; // strobe suppression level

  // tick clock edge finder
  wdbf_fall_det u_tick_fall (
    .clk(CLK),
    .arst_n(ARST_N),
    .level_in(TICK_CLOCK),
    .fall_pulse(tick_fall)
  );

  // data strobe edge finder
  wdbf_fall_det u_strobe_fall (
    .clk(CLK),
    .arst_n(ARST_N),
    .level_in(DATA_STROBE_N),
    .fall_pulse(strobe_fall)
  );

  // R14: wrap detect
  assign wdg_ovf = tick_fall & (&wdg_cnt_ff);

  // reload register, any 16-bit value accepted
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      // R02: cleared on reset
      reload_ff <= `WDBF_RELOAD_RST;
    end else if (RELOAD_WR) begin
      reload_ff <= RELOAD_DATA;
    end
  end

  // watchdog counter, live straight out of reset
  // R06: period is (65536 - reload) ticks of 10us
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      // R04: counting starts at reset
      wdg_cnt_ff <= `WDBF_CNT_RST;
    end else if (WDOG_GO) begin
      // R14: reload copies value
      wdg_cnt_ff <= reload_ff;
    end else if (tick_fall) begin
      // R01: advance on tick fall
      // R03: no value stops this
      wdg_cnt_ff <= wdg_cnt_ff + 1'b1;
    end
  end

  // expiry output; an overflow in the reload cycle still expires
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      expired_n_ff <= 1'b1;
    end else if (wdg_ovf) begin
      // R05: drop on overflow
      expired_n_ff <= 1'b0;
    end else if (WDOG_GO) begin
      // R05: release on reload
      expired_n_ff <= 1'b1;
    end
  end

  // R08: second tick fall without ready
  assign bus_to = (bft_state_ff == BFT_WAIT) & tick_fall & BUS_READY_N &
                  (ticks_ff == `WDBF_TO_TICKS - 2'h1) & TIMEOUT_DISABLE_N;

  // bus fault timer sequence
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bft_state_ff <= BFT_IDLE;
    end else if (!TIMEOUT_DISABLE_N) begin
      // R11: held reset
      bft_state_ff <= BFT_IDLE;
    end else begin
      case (bft_state_ff)
        // R07: start at strobe fall
        BFT_IDLE: begin
          if (strobe_fall) begin
            bft_state_ff <= BFT_WAIT;
          end
        end
        // R07: ready stops the timer
        BFT_WAIT: begin
          if (!BUS_READY_N) begin
            bft_state_ff <= BFT_IDLE;
          end else if (bus_to) begin
            bft_state_ff <= BFT_SUPPRESS;
          end
        end
        // strobes held off until this cycle's strobe ends
        BFT_SUPPRESS: begin
          if (DATA_STROBE_N) begin
            bft_state_ff <= BFT_IDLE;
          end
        end
        default: begin
          bft_state_ff <= BFT_IDLE;
        end
      endcase
    end
  end

  // tick counter and transfer type, restarted at each strobe fall
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ticks_ff <= `WDBF_TICKS_RST;
      is_io_ff <= 1'b0;
    end else if (strobe_fall) begin
      // first tick may come at once, so timeout lands in 1-2 ticks
      ticks_ff <= `WDBF_TICKS_RST;
      is_io_ff <= XFER_IS_IO;
    end else if (bft_state_ff == BFT_WAIT && tick_fall) begin
      ticks_ff <= ticks_ff + 2'h1;
    end
  end

  // bits to set on a timeout
  always_comb begin
    fault_set = '0;
    if (bus_to) begin
      if (is_io_ff) begin
        fault_set[`WDBF_BIT_IO_TO] = 1'b1;
      end else begin
        fault_set[`WDBF_BIT_MEM_TO] = 1'b1;
      end
    end
  end

  // fault register; a set in the clear cycle survives
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_ff <= `WDBF_FAULT_RST;
    end else if (READ_CLEAR_FAULT_CMD) begin
      // R13: cleared only here
      fault_ff <= fault_set;
    end else begin
      // R08: set fault bit
      fault_ff <= fault_ff | fault_set;
    end
  end

  // one-cycle reactions to a timeout
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      l1_req_ff <= 1'b0;
      abort_ff <= 1'b0;
      abandon_ff <= 1'b0;
      vector_ff <= 1'b0;
    end else begin
      // R09: level 1 and abort
      l1_req_ff <= bus_to;
      abort_ff <= bus_to;
      // R10: abandon and vector
      abandon_ff <= bus_to;
      vector_ff <= bus_to & LEVEL1_UNMASKED;
    end
  end

  // suppression flop tracks the suppress state so the pin comes from a flop
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      suppress_ff <= 1'b0;
    end else if (!TIMEOUT_DISABLE_N) begin
      // disabled timer never suppresses
      suppress_ff <= 1'b0;
    end else if (bus_to) begin
      // R09: hold strobes off
      suppress_ff <= 1'b1;
    end else if (DATA_STROBE_N) begin
      // strobe back high ends the aborted cycle
      suppress_ff <= 1'b0;
    end
  end

  // outputs straight from flops
  assign WATCHDOG_EXPIRED_N = expired_n_ff;
  assign FAULT_REGISTER = fault_ff;
  assign LEVEL1_INT_REQ = l1_req_ff;
  // R09: strobe suppression
  assign STROBE_SUPPRESS = suppress_ff;
  assign BUS_ABORT = abort_ff;
  assign INSTR_ABANDON = abandon_ff;
  assign LEVEL1_VECTOR = vector_ff;

  // counter steps by one on a plain tick
  property p_wdg_step;
    @(posedge CLK) disable iff (!ARST_N)
    (tick_fall && !WDOG_GO) |=> (wdg_cnt_ff == $past(wdg_cnt_ff) + 16'h0001);
  endproperty
  a_wdg_step: assert property (p_wdg_step) else $error("watchdog did not step"); // R01

  // reload register takes written value
  property p_reload_wr;
    @(posedge CLK) disable iff (!ARST_N)
    RELOAD_WR |=> (reload_ff == $past(RELOAD_DATA));
  endproperty
  a_reload_wr: assert property (p_reload_wr) else $error("reload value lost"); // R02

  // overflow drives expiry low
  property p_wdg_expire;
    @(posedge CLK) disable iff (!ARST_N)
    (tick_fall && (&wdg_cnt_ff)) |=> !WATCHDOG_EXPIRED_N;
  endproperty
  a_wdg_expire: assert property (p_wdg_expire) else $error("no expiry on wrap"); // R05

  // expiry holds until the reload command
  property p_wdg_hold;
    @(posedge CLK) disable iff (!ARST_N)
    (!WATCHDOG_EXPIRED_N && !WDOG_GO) |=> !WATCHDOG_EXPIRED_N;
  endproperty
  a_wdg_hold: assert property (p_wdg_hold) else $error("expiry released early"); // R05

  // reload copies the register
  property p_wdg_go;
    @(posedge CLK) disable iff (!ARST_N)
    WDOG_GO |=> (wdg_cnt_ff == $past(reload_ff));
  endproperty
  a_wdg_go: assert property (p_wdg_go) else $error("reload not copied"); // R14

  // strobe fall arms the timer
  property p_bft_start;
    @(posedge CLK) disable iff (!ARST_N)
    (strobe_fall && TIMEOUT_DISABLE_N && bft_state_ff == BFT_IDLE) |=>
      (bft_state_ff == BFT_WAIT && ticks_ff == 2'h0);
  endproperty
  a_bft_start: assert property (p_bft_start) else $error("timer not started"); // R07

  // ready clears the timer with no fault
  property p_bft_ready;
    @(posedge CLK) disable iff (!ARST_N)
    (bft_state_ff == BFT_WAIT && !BUS_READY_N) |=> (bft_state_ff == BFT_IDLE && !LEVEL1_INT_REQ);
  endproperty
  a_bft_ready: assert property (p_bft_ready) else $error("ready ignored"); // R07

  // timeout sets the right fault bit
  property p_fault_bit;
    @(posedge CLK) disable iff (!ARST_N)
    bus_to |=> (is_io_ff ? FAULT_REGISTER[`WDBF_BIT_IO_TO] : FAULT_REGISTER[`WDBF_BIT_MEM_TO]);
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit not set"); // R08

  // timeout raises level 1 and suppresses strobes
  property p_timeout_act;
    @(posedge CLK) disable iff (!ARST_N)
    bus_to |=> (LEVEL1_INT_REQ && BUS_ABORT && INSTR_ABANDON && STROBE_SUPPRESS) ##1
      !LEVEL1_INT_REQ;
  endproperty
  a_timeout_act: assert property (p_timeout_act) else $error("timeout not acted on"); // R09

  // disable input keeps the timer idle and silent
  property p_disable;
    @(posedge CLK) disable iff (!ARST_N)
    (!TIMEOUT_DISABLE_N)[*2] |-> (bft_state_ff == BFT_IDLE && !LEVEL1_INT_REQ);
  endproperty
  a_disable: assert property (p_disable) else $error("timer active while disabled"); // R11

  // memory timeout fault bit 8 stays until cleared
  property p_fault_sticky;
    @(posedge CLK) disable iff (!ARST_N)
    (FAULT_REGISTER[`WDBF_BIT_MEM_TO] && !READ_CLEAR_FAULT_CMD) |=>
      FAULT_REGISTER[`WDBF_BIT_MEM_TO];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault bit lost"); // R13

endmodule // wdbf_top

`default_nettype wire

/* File: bench/wdbf_ready_model.sv */
// ready responder standing for the memory and i/o devices
`timescale 1ns/100ps
`default_nettype none

module wdbf_ready_model (
  // clock
  input wire logic clk,
  // bus side
  input wire logic strobe_n,
  input wire logic [15:0] delay,
  output logic ready_n
);
  // cycles since strobe fell
  int cnt;

  // count while selected; idle restarts the wait
  always @(posedge clk) begin
    if (strobe_n) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // ready after delay
  // delay zero plays a dead device; pulled-up line reads high when released
  assign ready_n = !(!strobe_n && (delay != 16'h0000) && (cnt >= delay));
endmodule // wdbf_ready_model

`default_nettype wire

/* File: bench/wdbf_top_tb_top.sv */
// self-checking bench for the watchdog and bus fault timer
`timescale 1ns/100ps
`default_nettype none

module wdbf_top_tb_top;
  import wdbf_pkg::*;
  // clock, reset and tick
  logic CLK = 1'b0, ARST_N = 1'b0, TICK_CLOCK = 1'b1;
  // watchdog controls
  logic RELOAD_WR = 1'b0, WDOG_GO = 1'b0, EXP_N;
  logic [15:0] RELOAD_DATA = 16'h0000;
  // bus side
  logic DATA_STROBE_N = 1'b1, XFER_IS_IO = 1'b0, RDY_N, TO_DIS_N = 1'b1;
  logic CLR = 1'b0, UNMASK = 1'b0, INT_REQ, SUPP, ABORT, ABAND, VEC;
  logic [15:0] FAULT, dly = 16'h0000;
  int fail_count = 0, tests_run = 0, cyc = 0;

  // 100kHz tick: 400 cycles, half high half low
  // tick pulse train
  always @(negedge CLK) begin
    cyc <= cyc + 1;
    TICK_CLOCK <= ((cyc % 400) < 200);
    if (cyc == 30000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  initial begin
    forever #12.5 CLK = ~CLK;
  end

  wdbf_top dut (.CLK(CLK), .ARST_N(ARST_N), .TICK_CLOCK(TICK_CLOCK), .RELOAD_WR(RELOAD_WR),
    .RELOAD_DATA(RELOAD_DATA), .WDOG_GO(WDOG_GO), .WATCHDOG_EXPIRED_N(EXP_N),
    .DATA_STROBE_N(DATA_STROBE_N), .XFER_IS_IO(XFER_IS_IO), .BUS_READY_N(RDY_N),
    .TIMEOUT_DISABLE_N(TO_DIS_N), .READ_CLEAR_FAULT_CMD(CLR), .FAULT_REGISTER(FAULT),
    .LEVEL1_UNMASKED(UNMASK), .LEVEL1_INT_REQ(INT_REQ), .STROBE_SUPPRESS(SUPP),
    .BUS_ABORT(ABORT), .INSTR_ABANDON(ABAND), .LEVEL1_VECTOR(VEC));
  wdbf_ready_model rdy (.clk(CLK), .strobe_n(DATA_STROBE_N), .delay(dly), .ready_n(RDY_N));

  // compare one value, count it
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle pulse on a control, at the falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
  endtask

  // wait past the next tick fall
  task automatic tick_wait();
    @(negedge TICK_CLOCK);
    repeat (3) @(negedge CLK);
  endtask

  // counting, overflow, hold-low and release
  task automatic t_wdog();
    RELOAD_DATA = 16'hfffe;
    pulse(RELOAD_WR);
    tick_wait();
    pulse(WDOG_GO);
    tick_wait();
    chk(EXP_N, 1'b1);
    tick_wait();
    chk(EXP_N, 1'b0);
    tick_wait();
    chk(EXP_N, 1'b0);
    RELOAD_DATA = 16'h0000;
    pulse(RELOAD_WR);
    pulse(WDOG_GO);
    chk(EXP_N, 1'b1);
    repeat (3) tick_wait();
    chk(EXP_N, 1'b1);
    $display("test t_wdog done");
  endtask

  // one transfer; io kind, ready delay, disable level, fault expected
  task automatic t_bus(input logic io, input logic [15:0] d, input logic dis_n,
                       input logic um, input logic [15:0] exp);
    int at, n;
    at = 0;
    n = 0;
    XFER_IS_IO = io;
    dly = d;
    TO_DIS_N = dis_n;
    UNMASK = um;
    DATA_STROBE_N = 1'b0;
    for (int i = 1; i < 900; i++) begin
      @(negedge CLK);
      if (ABORT === 1'b1) begin
        at = i;
        n = n + 1;
        chk({INT_REQ, ABAND, SUPP, VEC}, {3'h7, um});
      end
    end
    chk(FAULT, exp);
    chk(n, (exp != 16'h0000));
    if (n != 0) begin
      chk((at >= 400) && (at <= 802), 1'b1);
    end
    chk(SUPP, |exp);
    DATA_STROBE_N = 1'b1;
    repeat (3) @(negedge CLK);
    chk(SUPP, 1'b0);
    chk(FAULT, exp);
    pulse(CLR);
    @(negedge CLK);
    chk(FAULT, 16'h0000);
    $display("test t_bus done");
  endtask

  // verdict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge CLK);
    ARST_N = 1'b1;
    @(negedge CLK);
    chk({EXP_N, FAULT}, 17'h10000);
    t_wdog();
    t_bus(1'b0, 16'h0000, 1'b1, 1'b1, 16'h0100);
    t_bus(1'b1, 16'h0000, 1'b1, 1'b0, 16'h0020);
    t_bus(1'b1, 16'h0032, 1'b1, 1'b1, 16'h0000);
    t_bus(1'b0, 16'h0000, 1'b0, 1'b1, 16'h0000);
    test_done();
  end
endmodule // wdbf_top_tb_top

`default_nettype wire
